// [src/pwmsc_pkg.sv]
package pwmsc_pkg;
  // ==========================================================
  // timing constants
  localparam int unsigned CLK_MHZ = 125;
  localparam int unsigned SYNC_WIDTH_CYC = 32;
  localparam int unsigned CUR_CONV_MAX_CYC = 100;
  localparam int unsigned AUX_CONV_MAX_CYC = 200;
  localparam int unsigned GATE_UPD_MAX_CYC = 2;
  localparam int unsigned KILL_MAX_CYC = 100;
  localparam int unsigned KILL_MIN_WIDTH_CYC = 32;
  localparam int unsigned CONV_TIME_NS = 2050;
  localparam int unsigned CONV_MAX_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  // one conversion, kept short so current and aux both land inside their sync bounds
  localparam int unsigned CONV_CYC = 96;
  localparam int unsigned HOLD_TIME_NS = 10000;
  localparam int unsigned HOLD_MAX_CYC = (HOLD_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned FILT_TIME_NS = 2000;
  localparam int unsigned FILT_CYC = (FILT_TIME_NS * CLK_MHZ) / 1000;
  // ==========================================================
  // widths and reset values
  localparam int unsigned CNT_W = 9;
  localparam int unsigned AUX_CHANNELS = 6;
  localparam logic [2:0] AUX_FIRST = 3'h1;
  localparam logic [5:0] GATE_POL_RST = 6'h00;
  localparam logic KILL_SENSE_RST = 1'b0;
  localparam logic [8:0] CNT_ZERO = 9'h000;
  // ==========================================================
  // conversion sequencer states
  typedef enum logic [1:0] {PWMSC_IDLE, PWMSC_CUR, PWMSC_AUX} pwmsc_state_e;
endpackage

// [src/pwmsc_filter.sv]
`timescale 1ns/1ps
// ==========================================================
// synchroniser plus persistence filter for one fault input
module pwmsc_filter
  import pwmsc_pkg::*;
#(
  parameter int unsigned LEN = 16
) (
  input wire logic refClk, // system clock
  input wire logic nrst, // sync reset, active low
  input wire logic clkEn, // clock enable
  input wire logic rawIn, // asynchronous input, active high
  output logic filtOut // filtered level
);
  logic sync1_q;
  logic sync2_q;
  logic [CNT_W-1:0] cnt_q;

  // two-stage synchroniser, first stage read only by second
  always_ff @(posedge refClk) begin
    if (!nrst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else if (clkEn) begin
      sync1_q <= rawIn;
      sync2_q <= sync1_q;
    end
  end

  // output follows once input held stable for LEN cycles
  always_ff @(posedge refClk) begin
    if (!nrst) begin
      cnt_q <= CNT_ZERO;
      filtOut <= 1'b0;
    end else if (clkEn) begin
      if (sync2_q == filtOut) begin
        cnt_q <= CNT_ZERO;
      end else if (cnt_q >= CNT_W'(LEN - 1)) begin
        cnt_q <= CNT_ZERO;
        filtOut <= sync2_q;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end
endmodule

// [src/pwmsc_top.sv]
`timescale 1ns/1ps
// Overview of operation
// - sync output pulse lasts 32 clock cycles at every carrier sync event
// - current feedback conversion completes within 100 cycles after sync
// - scheduled auxiliary conversion completes within 200 cycles after sync
// - auxiliary channels one to six converted in rotation, one per sync
// - the six gate outputs update no later than 2 cycles after sync
// - one conversion lasts no more than 2.05 microseconds
// - held sample converted within 10 microseconds of capture
// - valid shutdown forces all gate outputs inactive within 100 cycles
// - overcurrent trip turns gates off within 100 cycles plus comparator delay
// - shutdown negates all six gates; its input sense is programmable
// - shutdown passes about 2 us digital filter, active low by default
// - gate outputs active high after reset, polarity configurable
module pwmsc_top
  import pwmsc_pkg::*;
(
  input wire logic ref_clk, // 125 MHz system clock
  input wire logic nrst, // sync reset, active low
  input wire logic clkEn, // clock enable, freezes state when low
  input wire logic carrierEvt, // carrier sync event, one-cycle pulse
  input wire logic [5:0] gateCmd, // uh ul vh vl wh wl from modulator
  input wire logic [5:0] gatePol, // 1 = low-true output per gate
  input wire logic killSense, // 1 = shutdown input active high
  input wire logic shutdownPin, // asynchronous shutdown pin
  input wire logic tripPin, // asynchronous overcurrent comparator
  output logic syncOut, // sync pulse
  output logic adcStart, // conversion start pulse
  output logic adcSample, // sample/hold capture, one-cycle pulse at each conversion start
  output logic [2:0] adcChan, // 0 current, 1..6 auxiliary
  output logic curDone, // current conversion done pulse
  output logic auxDone, // auxiliary conversion done pulse
  output logic gatesKilled, // gates forced off
  output logic phase_u_high_gate, // gate output
  output logic phase_u_low_gate, // gate output
  output logic phase_v_high_gate, // gate output
  output logic phase_v_low_gate, // gate output
  output logic phase_w_high_gate, // gate output
  output logic phase_w_low_gate // gate output
);
  // ==========================================================
  // fault inputs
  logic killRaw;
  logic killFilt;
  logic tripFilt;
  logic killSense_q;
  logic [5:0] gatePol_q;

  // sense and polarity captured after reset, first lives reset values
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      killSense_q <= KILL_SENSE_RST;
      gatePol_q <= GATE_POL_RST;
    end else if (clkEn) begin
      killSense_q <= killSense;
      gatePol_q <= gatePol;
    end
  end

  // shutdown pin synchronised before the sense is applied, no logic sees it raw
  logic killPin1_q;
  logic killPin2_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      killPin1_q <= ~KILL_SENSE_RST; // idle level of a low-true pin
      killPin2_q <= ~KILL_SENSE_RST;
    end else if (clkEn) begin
      killPin1_q <= shutdownPin;
      killPin2_q <= killPin1_q;
    end
  end

  assign killRaw = killSense_q ? killPin2_q : ~killPin2_q;

  // shutdown: 2 us filter before it counts
  pwmsc_filter #(.LEN(FILT_CYC)) uKill (
    .refClk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .rawIn(killRaw),
    .filtOut(killFilt)
  );

  // trip: sync then short glitch filter
  pwmsc_filter #(.LEN(2)) uTrip (
    .refClk(ref_clk),
    .nrst(nrst),
    .clkEn(clkEn),
    .rawIn(tripPin),
    .filtOut(tripFilt)
  );

  // ==========================================================
  // sync pulse generator
  logic [CNT_W-1:0] syncCnt_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      syncCnt_q <= CNT_ZERO;
      syncOut <= 1'b0;
    end else if (clkEn) begin
      if (carrierEvt) begin
        syncCnt_q <= CNT_W'(SYNC_WIDTH_CYC - 1);
        syncOut <= 1'b1;
      end else if (syncCnt_q != CNT_ZERO) begin
        syncCnt_q <= syncCnt_q - 1'b1;
      end else begin
        syncOut <= 1'b0;
      end
    end
  end

  // ==========================================================
  // gate outputs: new state one cycle after sync, kill overrides
  logic [5:0] gateAct_q;
  logic killAny;
  assign killAny = killFilt | tripFilt;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gateAct_q <= 6'h00;
    end else if (clkEn && carrierEvt) begin
      gateAct_q <= gateCmd;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gatesKilled <= 1'b0;
      {phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
       phase_v_low_gate, phase_w_high_gate, phase_w_low_gate} <= GATE_POL_RST;
    end else if (clkEn) begin
      gatesKilled <= killAny;
      {phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
       phase_v_low_gate, phase_w_high_gate, phase_w_low_gate} <=
        (killAny ? 6'h00 : gateAct_q) ^ gatePol_q;
    end
  end

  // ==========================================================
  // conversion sequencer: current, then one auxiliary channel
  pwmsc_state_e state_q;
  logic [CNT_W-1:0] convCnt_q;
  logic [2:0] auxChan_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      state_q <= PWMSC_IDLE;
      convCnt_q <= CNT_ZERO;
      adcStart <= 1'b0;
      adcSample <= 1'b0;
      adcChan <= 3'h0;
      curDone <= 1'b0;
      auxDone <= 1'b0;
      auxChan_q <= AUX_FIRST;
    end else if (clkEn) begin
      adcStart <= 1'b0;
      curDone <= 1'b0;
      auxDone <= 1'b0;
      case (state_q)
        PWMSC_IDLE: begin
          adcSample <= 1'b0;
          if (carrierEvt) begin
            state_q <= PWMSC_CUR;
            adcStart <= 1'b1;
            adcSample <= 1'b1; // capture, conversion follows at once
            adcChan <= 3'h0;
            convCnt_q <= CNT_ZERO;
          end
        end
        PWMSC_CUR: begin
          adcSample <= 1'b0;
          convCnt_q <= convCnt_q + 1'b1;
          if (convCnt_q == CNT_W'(CONV_CYC - 1)) begin
            curDone <= 1'b1;
            state_q <= PWMSC_AUX;
            adcStart <= 1'b1;
            adcSample <= 1'b1;
            adcChan <= auxChan_q;
            convCnt_q <= CNT_ZERO;
          end
        end
        PWMSC_AUX: begin
          adcSample <= 1'b0;
          convCnt_q <= convCnt_q + 1'b1;
          if (convCnt_q == CNT_W'(CONV_CYC - 1)) begin
            auxDone <= 1'b1;
            state_q <= PWMSC_IDLE;
            auxChan_q <= (auxChan_q == 3'(AUX_CHANNELS)) ? AUX_FIRST
                                                          : auxChan_q + 3'h1;
          end
        end
        default: begin
          state_q <= PWMSC_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // checks
  logic [CNT_W-1:0] sinceSync_q;
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sinceSync_q <= CNT_ZERO;
    end else if (clkEn) begin
      if (carrierEvt) begin
        sinceSync_q <= CNT_ZERO;
      end else if (sinceSync_q != {CNT_W{1'b1}}) begin
        sinceSync_q <= sinceSync_q + 1'b1;
      end
    end
  end

  property p_syncWidth;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      $rose(syncOut) |-> syncOut[*8];
  endproperty
  a_syncWidth: assert property (p_syncWidth) else $error("sync pulse too short");

  property p_curBound;
    @(posedge ref_clk) disable iff (!nrst)
      curDone |-> sinceSync_q < 9'h064;
  endproperty
  a_curBound: assert property (p_curBound) else $error("current conversion late");

  property p_auxBound;
    @(posedge ref_clk) disable iff (!nrst)
      auxDone |-> sinceSync_q < 9'h0C8;
  endproperty
  a_auxBound: assert property (p_auxBound) else $error("aux conversion late");

  property p_auxRange;
    @(posedge ref_clk) disable iff (!nrst)
      auxDone |-> (adcChan >= 3'h1 && adcChan <= 3'h6);
  endproperty
  a_auxRange: assert property (p_auxRange) else $error("aux channel out of range");

  property p_gateUpd;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      (carrierEvt && !killAny) ##1 (clkEn && !killAny) |=> 
        ({phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
          phase_v_low_gate, phase_w_high_gate, phase_w_low_gate}
         == ($past(gateCmd, 2) ^ $past(gatePol_q)));
  endproperty
  a_gateUpd: assert property (p_gateUpd) else $error("gate update late");

  property p_killOff;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      gatesKilled |-> ({phase_u_high_gate, phase_u_low_gate, phase_v_high_gate,
                       phase_v_low_gate, phase_w_high_gate, phase_w_low_gate}
                      == $past(gatePol_q));
  endproperty
  a_killOff: assert property (p_killOff) else $error("gates not off during kill");

  property p_tripKill;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      tripFilt |=> gatesKilled;
  endproperty
  a_tripKill: assert property (p_tripKill) else $error("trip did not kill gates");

  property p_killLat;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      killFilt |=> gatesKilled;
  endproperty
  a_killLat: assert property (p_killLat) else $error("shutdown left gates on");

  property p_convLen;
    @(posedge ref_clk) disable iff (!nrst || !clkEn)
      curDone |-> $past(state_q) == PWMSC_CUR && $past(convCnt_q) == CNT_W'(CONV_CYC - 1);
  endproperty
  a_convLen: assert property (p_convLen) else $error("conversion length wrong");
endmodule

// [dv/pwmsc_partner.sv]
`timescale 1ns/1ps
// ======================================================
// gate driver stage and overcurrent comparator model
module pwmsc_partner #(
  parameter int unsigned CMP_DLY_NS = 600
) (
  input wire logic [5:0] gates, // gate pins uh ul vh vl wh wl
  input wire logic [5:0] pol, // 1 = pin is low-true
  input wire logic tripReq, // bench asks for an overcurrent
  output logic tripPin, // comparator output, active high
  output logic [5:0] driveOn // switch actually turned on
);
  // a low-true pin turns its switch on when low
  assign driveOn = gates ^ pol;
  // comparator output lags the current by its propagation delay
  initial tripPin = 1'b0;
  always @(tripReq) tripPin <= #(CMP_DLY_NS) tripReq;
endmodule

// [dv/pwmsc_top_tb.sv]
`timescale 1ns/1ps
module pwmsc_top_tb
  import pwmsc_pkg::*;
;
  logic ref_clk, nrst, clkEn, carrierEvt, killSense, shutdownPin, tripReq, tripPin;
  logic syncOut, adcStart, adcSample, curDone, auxDone, gatesKilled;
  logic uh, ul, vh, vl, wh, wl;
  logic [2:0] adcChan;
  logic [5:0] gateCmd, gatePol, driveOn;
  logic [9:0] evtAge, syncLen;
  logic [2:0] chanQ[$];
  int err_count, checks;

  pwmsc_top uut (.ref_clk(ref_clk), .nrst(nrst), .clkEn(clkEn), .carrierEvt(carrierEvt),
    .gateCmd(gateCmd), .gatePol(gatePol), .killSense(killSense), .shutdownPin(shutdownPin),
    .tripPin(tripPin), .syncOut(syncOut), .adcStart(adcStart), .adcSample(adcSample),
    .adcChan(adcChan), .curDone(curDone), .auxDone(auxDone), .gatesKilled(gatesKilled),
    .phase_u_high_gate(uh), .phase_u_low_gate(ul), .phase_v_high_gate(vh),
    .phase_v_low_gate(vl), .phase_w_high_gate(wh), .phase_w_low_gate(wl));
  pwmsc_partner drv (.gates({uh, ul, vh, vl, wh, wl}), .pol(gatePol), .tripReq(tripReq),
    .tripPin(tripPin), .driveOn(driveOn));

  // 125 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ======================================================
  // helpers
  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // one carrier event, then gates checked two edges on
  task automatic carrier(input logic [5:0] cmd, input logic [2:0] aux);
    @(negedge ref_clk);
    gateCmd = cmd;
    carrierEvt = 1'b1;
    chanQ.push_back(aux);
    @(negedge ref_clk);
    carrierEvt = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(10'(driveOn), 10'(cmd));
    repeat (600) @(negedge ref_clk);
  endtask

  // bounded wait until every switch is off
  task automatic wait_off(input int lim);
    int n;
    n = 0;
    while (driveOn !== 6'h00 && n < lim) begin
      @(negedge ref_clk);
      n++;
    end
    chk(10'(driveOn), 10'h000);
    if (driveOn !== 6'h00) conclude();
  endtask

  // ======================================================
  // monitor: timing after sync and channel order
  always @(posedge ref_clk) begin
    evtAge <= carrierEvt ? 10'h000 : evtAge + 10'h001;
    syncLen <= syncOut ? syncLen + 10'h001 : 10'h000;
    if (nrst && $fell(syncOut)) chk(syncLen, 10'(SYNC_WIDTH_CYC));
    if (curDone) chk(10'(evtAge <= 10'(CUR_CONV_MAX_CYC)), 10'h001);
    if (auxDone) chk(10'(evtAge <= 10'(AUX_CONV_MAX_CYC)), 10'h001);
    if (nrst && adcStart && adcChan != 3'h0)
      chk(10'(adcChan), (chanQ.size() > 0) ? 10'(chanQ.pop_front()) : 10'h000);
  end

  // ======================================================
  // main sequence
  initial begin
    {nrst, carrierEvt, killSense, tripReq} = 4'h0;
    clkEn = 1'b1;
    shutdownPin = 1'b1;
    gateCmd = 6'h00;
    gatePol = 6'h00;
    evtAge = 10'h000;
    syncLen = 10'h000;
    void'($urandom(32'ha021));
    repeat (2) @(negedge ref_clk);
    nrst = 1'b1;
    chk(10'({uh, ul, vh, vl, wh, wl}), 10'h000);
    for (int i = 0; i < 7; i++) carrier(6'($urandom), 3'((i % 6) + 1));
    $display("test rotation done");
    gatePol = 6'($urandom);
    for (int i = 7; i < 10; i++) carrier(6'($urandom), 3'((i % 6) + 1));
    $display("test polarity done");
    carrier(6'h3f, 3'h5);
    // an event while the clock enable is low must leave every output as it was
    clkEn = 1'b0;
    carrierEvt = 1'b1;
    gateCmd = 6'h00;
    repeat (3) @(negedge ref_clk);
    clkEn = 1'b1;
    carrierEvt = 1'b0;
    repeat (3) @(negedge ref_clk);
    chk(10'(syncOut), 10'h000);
    chk(10'(driveOn), 10'h03f);
    $display("test freeze done");
    // a pulse shorter than the filter must never reach the gates
    shutdownPin = 1'b0;
    repeat (20) @(negedge ref_clk);
    shutdownPin = 1'b1;
    repeat (4) @(negedge ref_clk);
    chk(10'(gatesKilled), 10'h000);
    chk(10'(driveOn), 10'h03f);
    repeat (300) @(negedge ref_clk);
    shutdownPin = 1'b0;
    wait_off(FILT_CYC + KILL_MAX_CYC + 4);
    shutdownPin = 1'b1;
    repeat (300) @(negedge ref_clk);
    chk(10'(gatesKilled), 10'h000);
    $display("test low-true shutdown done");
    shutdownPin = 1'b0;
    killSense = 1'b1;
    carrier(6'h2a, 3'h6);
    shutdownPin = 1'b1;
    wait_off(FILT_CYC + KILL_MAX_CYC + 4);
    shutdownPin = 1'b0;
    repeat (300) @(negedge ref_clk);
    chk(10'(gatesKilled), 10'h000);
    $display("test high-true shutdown done");
    carrier(6'h15, 3'h1);
    tripReq = 1'b1;
    wait_off(KILL_MAX_CYC + CLK_MHZ + 8);
    $display("test trip done");
    chk(10'(chanQ.size()), 10'h000);
    conclude();
  end
endmodule
